// [rtl/alert_bank_pkg.sv]
// Constants and types for the alert flag and enable bank
package alert_bank_pkg;

    // ****************************************
    // Register write addresses; reads use write address plus one
    // ****************************************
    localparam logic [7:0] TX_EN_WR_ADDR = 8'h00;
    localparam logic [7:0] PIN_FLAGS_WR_ADDR = 8'h1E;
    localparam logic [7:0] RX_EN_WR_ADDR = 8'h20;
    localparam logic [7:0] LOCKSTEP_EN_WR_ADDR = 8'h24;
    localparam logic [7:0] READ_ADDR_STEP = 8'h01;

    // ****************************************
    // Reset values and field layout
    // ****************************************
    localparam logic [7:0] TX_EN_RESET = 8'h00;
    localparam logic [7:0] PIN_FLAGS_RESET = 8'h00;
    localparam logic [7:0] RX_EN_RESET = 8'h00;
    localparam logic [7:0] LOCKSTEP_EN_RESET = 8'h01;
    // Bit 6 of the receive and transmit enables is unused and reads zero
    localparam logic [7:0] RX_EN_MASK = 8'hBF;
    localparam logic [7:0] TX_EN_MASK = 8'hBF;
    localparam int PIN_COUNT = 4;

    // ****************************************
    // Timing
    // ****************************************
    // Readback path: three sync stages plus the agreement filter
    localparam int READBACK_LATENCY = 4;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

endpackage

// [rtl/pin_readback_sync.sv]
// Three-stage synchroniser with agreement filter for pin readback
`timescale 1ns/1ps
`default_nettype none
module pin_readback_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Asynchronous pin levels
    input wire logic [WIDTH-1:0] pin_async,
    // Filtered levels
    output logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;
    // Stage one feeds stage two only
    wire logic [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
    wire logic [WIDTH-1:0] level_d = (agree & s3_q) | (~agree & level_q);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_q <= '0;
        end else begin
            s1_q <= pin_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign pin_level = level_q;
endmodule
`default_nettype wire

// [rtl/alert_flag_enable_bank.sv]
// Pin continuity flags, event enables and alert output of the bridge
// Function
// - Each of the four pins sets its continuity flag when its driven value differs from readback.
// - Writing zero to a flag bit clears it, writing one leaves it, and reads return the flags.
// - A flag stays set while its mismatch condition persists, whatever clearing writes arrive.
// - The receive enable register holds read/write enables at bits 7 and 5..0, bit 6 unused.
// - The transmit enable register holds read/write enables at bits 7 and 5..0, resetting to zero.
// - The lock-step enable register holds eight read/write enables for lock-step events.
// - After reset the lock-step hardware fault enable reads one and all else reads zero.
// - Each register is written at an even address and read at that address plus one.
`timescale 1ns/1ps
`default_nettype none
module alert_flag_enable_bank
    import alert_bank_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Host register access
    input wire alert_bank_pkg::host_req_t host_req,
    output logic [7:0] host_rdata,
    // General-purpose pins: driven value and raw readback
    input wire logic [PINS-1:0] pin_drive,
    input wire logic [PINS-1:0] pin_readback,
    // Enables for pin flags, held in a neighbouring register
    input wire logic [PINS-1:0] pin_fault_notify_enable,
    // Event status from the buffers and lock-step message checker
    input wire logic [7:0] receive_events,
    input wire logic [7:0] transmit_events,
    input wire logic [7:0] lockstep_events,
    // Alert output
    output logic alert
);
    import alert_bank_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] tx_en_q;
    logic [7:0] rx_en_q;
    logic [7:0] lockstep_en_q;
    logic [PINS-1:0] pin_flags_q;
    logic [7:0] rdata_q;
    logic alert_q;
    logic [PINS-1:0] drive_dly_q [READBACK_LATENCY];
    logic [PINS-1:0] pin_level;

    // ****************************************
    // Address decode
    // ****************************************
    wire logic wr_tx = host_req.wr && (host_req.addr == TX_EN_WR_ADDR);
    wire logic wr_pin = host_req.wr && (host_req.addr == PIN_FLAGS_WR_ADDR);
    wire logic wr_rx = host_req.wr && (host_req.addr == RX_EN_WR_ADDR);
    wire logic wr_ls = host_req.wr && (host_req.addr == LOCKSTEP_EN_WR_ADDR);
    wire logic rd_tx = host_req.rd && (host_req.addr == TX_EN_WR_ADDR + READ_ADDR_STEP);
    wire logic rd_pin = host_req.rd && (host_req.addr == PIN_FLAGS_WR_ADDR + READ_ADDR_STEP);
    wire logic rd_rx = host_req.rd && (host_req.addr == RX_EN_WR_ADDR + READ_ADDR_STEP);
    wire logic rd_ls = host_req.rd && (host_req.addr == LOCKSTEP_EN_WR_ADDR + READ_ADDR_STEP);

    // Unmapped reads return zero; narrow flags sit in the low bits
    wire logic [7:0] pin_flags_word = {{(8 - PINS){1'b0}}, pin_flags_q};
    wire logic [7:0] rdata_d = rd_tx ? tx_en_q :
                               rd_pin ? pin_flags_word :
                               rd_rx ? rx_en_q :
                               rd_ls ? lockstep_en_q :
                               (host_req.rd ? 8'h00 : rdata_q);

    // ****************************************
    // Pin readback and continuity flags
    // ****************************************
    pin_readback_sync #(
        .WIDTH(PINS)
    ) u_readback (
        .mclk(mclk),
        .reset_n(reset_n),
        .pin_async(pin_readback),
        .pin_level(pin_level)
    );

    // Drive is delayed to match readback latency so a legal edge is not a fault
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < READBACK_LATENCY; i++) begin
                drive_dly_q[i] <= '0;
            end
        end else begin
            drive_dly_q[0] <= pin_drive;
            for (int i = 1; i < READBACK_LATENCY; i++) begin
                drive_dly_q[i] <= drive_dly_q[i-1];
            end
        end
    end

    wire logic [PINS-1:0] mismatch = drive_dly_q[READBACK_LATENCY-1] ^ pin_level;

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            wire logic clear = wr_pin && !host_req.wdata[g];
            // Set beats clear, so a live mismatch keeps the flag up
            wire logic flag_d = mismatch[g] | (pin_flags_q[g] & ~clear);
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    pin_flags_q[g] <= PIN_FLAGS_RESET[g];
                end else begin
                    pin_flags_q[g] <= flag_d;
                end
            end
        end
    endgenerate

    // ****************************************
    // Enable registers
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_en_q <= TX_EN_RESET;
            rx_en_q <= RX_EN_RESET;
            lockstep_en_q <= LOCKSTEP_EN_RESET;
        end else begin
            if (wr_tx) begin
                tx_en_q <= host_req.wdata & TX_EN_MASK;
            end
            if (wr_rx) begin
                rx_en_q <= host_req.wdata & RX_EN_MASK;
            end
            if (wr_ls) begin
                lockstep_en_q <= host_req.wdata;
            end
        end
    end

    // ****************************************
    // Alert and read data
    // ****************************************
    wire logic alert_d = |(pin_flags_q & pin_fault_notify_enable) |
                         |(receive_events & rx_en_q) |
                         |(transmit_events & tx_en_q) |
                         |(lockstep_events & lockstep_en_q);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
            alert_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            alert_q <= alert_d;
        end
    end

    assign host_rdata = rdata_q;
    assign alert = alert_q;
endmodule
`default_nettype wire

// [dv/alert_bank_chk_sva.sv]
// Port assertions for the alert flag and enable bank
`timescale 1ns/1ps
`default_nettype none
module alert_bank_chk
    import alert_bank_pkg::*;
#(parameter int PINS = 4) (
    // Clock, reset and host port
    input wire logic mclk,
    input wire logic reset_n,
    input wire alert_bank_pkg::host_req_t host_req,
    input wire logic [7:0] host_rdata,
    // Pins, events and alert
    input wire logic [PINS-1:0] pin_drive,
    input wire logic [PINS-1:0] pin_readback,
    input wire logic [PINS-1:0] pin_fault_notify_enable,
    input wire logic [7:0] receive_events,
    input wire logic [7:0] transmit_events,
    input wire logic [7:0] lockstep_events,
    input wire logic alert
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Long enough to pass the readback filter and the flag flop
    sequence pin0_fault;
        (pin_drive[0] != pin_readback[0] && pin_fault_notify_enable[0]) [*7];
    endsequence
    sequence rd_at(logic [7:0] a);
        host_req.rd && host_req.addr == a;
    endsequence
    AST_PIN_FAULT: assert property (pin0_fault |=> alert)
        else $error("pin fault gave no alert");
    AST_ALERT_IDLE: assert property (receive_events == 8'h00 &&
        transmit_events == 8'h00 && lockstep_events == 8'h00 && pin_fault_notify_enable == '0
        |=> !alert) else $error("alert with nothing enabled set");
    AST_READ_EVEN: assert property (host_req.rd && !host_req.addr[0]
        |=> host_rdata == 8'h00) else $error("even read gave data");
    AST_READ_UNMAPPED: assert property (rd_at(8'h03) |=> host_rdata == 8'h00)
        else $error("unmapped read gave data");
    AST_RDATA_HOLD: assert property (!host_req.rd |=> $stable(host_rdata))
        else $error("read data moved without a read");
    AST_RX_GAP: assert property (rd_at(8'h21) |=> !host_rdata[6])
        else $error("rx bit 6 set");
    AST_TX_GAP: assert property (rd_at(8'h01) |=> !host_rdata[6])
        else $error("tx bit 6 set");
    AST_FLAG_WIDTH: assert property (rd_at(8'h1F) |=> host_rdata[7:4] == 4'h0)
        else $error("flag upper bits set");
endmodule
`default_nettype wire

// [dv/host_model.sv]
// Host microcontroller model issuing register strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock and read data
    input wire logic mclk,
    input wire logic [7:0] host_rdata,
    // Requests
    output var alert_bank_pkg::host_req_t host_req
);
    import alert_bank_pkg::*;
    initial host_req = '0;
    // Released lines show inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        host_req <= {2'b10, a, d};
        @(posedge mclk);
        host_req <= {2'b00, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        host_req <= {2'b01, a, 8'h00};
        @(posedge mclk);
        host_req <= {2'b00, ~a, 8'hFF};
        #1 d = host_rdata;
    endtask
endmodule
`default_nettype wire

// [dv/alert_flag_enable_bank_tb_top.sv]
// Self-checking bench for the alert flag and enable bank
`timescale 1ns/1ps
`default_nettype none
module alert_flag_enable_bank_tb_top;
    import alert_bank_pkg::*;
    localparam int PINS = 4;
    logic mclk, reset_n, alert;
    host_req_t host_req;
    logic [7:0] host_rdata, receive_events, transmit_events, lockstep_events, v;
    logic [PINS-1:0] pin_drive, pin_readback, pin_fault_notify_enable;
    int n_fail, total_checks;
    alert_flag_enable_bank #(.PINS(PINS)) alert_flag_enable_bank_i (.mclk, .reset_n,
        .host_req, .host_rdata, .pin_drive, .pin_readback, .pin_fault_notify_enable,
        .receive_events, .transmit_events, .lockstep_events, .alert);
    host_model host_model_i (.mclk, .host_rdata, .host_req);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string s);
        host_model_i.rd(a, v);
        chk(s, e, v);
    endtask
    task automatic t_reset_values();
        rc(8'h01, 8'h00, "tx enables");
        rc(8'h1F, 8'h00, "pin flags");
        rc(8'h21, 8'h00, "rx enables");
        rc(8'h25, 8'h01, "lockstep enables");
    endtask
    task automatic t_reg_access();
        host_model_i.wr(8'h00, 8'hFF);
        host_model_i.wr(8'h20, 8'hFF);
        host_model_i.wr(8'h25, 8'h00);
        rc(8'h01, 8'hBF, "tx enables");
        rc(8'h21, 8'hBF, "rx enables");
        rc(8'h25, 8'h01, "odd write");
        rc(8'h20, 8'h00, "even read");
        rc(8'h03, 8'h00, "unmapped read");
        host_model_i.wr(8'h24, 8'hFE);
        rc(8'h25, 8'hFE, "lockstep enables");
    endtask
    task automatic t_events();
        // Unused rx bit and the disabled lockstep bit first, then one enabled bit per group
        for (int g = 0; g < 4; g++) begin
            @(posedge mclk);
            {receive_events, transmit_events, lockstep_events} <= g == 0 ? 24'h400001 :
                24'h80 << (8 * (g - 1));
            repeat (2) @(posedge mclk);
            #1 chk("alert", {7'h00, g != 0}, {7'h00, alert});
        end
        // All groups idle again, so later alert checks see only the pin flags
        {receive_events, transmit_events, lockstep_events} <= '0;
    endtask
    task automatic t_pins();
        @(posedge mclk);
        pin_fault_notify_enable <= 4'h1;
        pin_readback <= 4'h4;
        repeat (8) @(posedge mclk);
        rc(8'h1F, 8'h01, "flag set");
        host_model_i.wr(8'h1E, 8'h00);
        rc(8'h1F, 8'h01, "flag held");
        chk("alert on flag", 8'h01, {7'h00, alert});
        @(posedge mclk);
        pin_readback <= 4'h5;
        repeat (8) @(posedge mclk);
        host_model_i.wr(8'h1E, 8'h01);
        rc(8'h1F, 8'h01, "write one");
        host_model_i.wr(8'h1E, 8'h00);
        rc(8'h1F, 8'h00, "write zero");
        repeat (2) @(posedge mclk);
        #1 chk("alert released", 8'h00, {7'h00, alert});
        // Drive and readback moving together must not raise a flag
        @(posedge mclk);
        {pin_drive, pin_readback} <= 8'hAA;
        repeat (8) @(posedge mclk);
        rc(8'h1F, 8'h00, "aligned drive change");
        @(posedge mclk);
        pin_drive <= 4'h2;
        repeat (8) @(posedge mclk);
        rc(8'h1F, 8'h08, "pin4 flag set");
        chk("pin4 not enabled", 8'h00, {7'h00, alert});
        @(posedge mclk);
        pin_drive <= 4'hA;
        repeat (8) @(posedge mclk);
        host_model_i.wr(8'h1E, 8'hF7);
        rc(8'h1F, 8'h00, "pin4 flag cleared");
    endtask
    task automatic do_reset();
        if (reset_n) begin
            @(posedge mclk);
            reset_n <= 1'b0;
        end
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        {reset_n, pin_fault_notify_enable, receive_events, transmit_events, lockstep_events} = '0;
        {pin_drive, pin_readback} = 8'h55;
        {n_fail, total_checks} = '0;
        do_reset();
        t_reset_values();
        t_reg_access();
        t_events();
        t_pins();
        do_reset();
        t_reset_values();
        test_done();
    end
    // The whole sequence needs about 130 cycles; over twenty times that means a hang
    initial begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        test_done();
    end
endmodule
bind alert_flag_enable_bank alert_bank_chk #(.PINS(PINS)) alert_bank_chk_i (.mclk, .reset_n,
    .host_req, .host_rdata, .pin_drive, .pin_readback, .pin_fault_notify_enable,
    .receive_events, .transmit_events, .lockstep_events, .alert);
`default_nettype wire
